// [common/plrx_pkg.sv]
// shared constants for the pcie lane idle, receiver detect and receive port block
package plrx_pkg;
    localparam int PLRX_CHANNELS = 4;
    localparam int PLRX_CLK_MHZ = 200;
    localparam int PLRX_IDLE_ENTER_NS = 120;
    localparam int PLRX_IDLE_ENTER_CYC = (PLRX_IDLE_ENTER_NS * PLRX_CLK_MHZ) / 1000;
    localparam int PLRX_IDLE_EXIT_NS = 100;
    localparam int PLRX_IDLE_EXIT_CYC = (PLRX_IDLE_EXIT_NS * PLRX_CLK_MHZ) / 1000;
    localparam logic [7:0] PLRX_REG_LOS_THR = 8'h28;
    localparam logic [7:0] PLRX_REG_CTRL = 8'h40;
    localparam logic [7:0] PLRX_REG_STATUS = 8'h44;
    localparam logic [7:0] PLRX_REG_IRQ_STAT = 8'h48;
    localparam logic [7:0] PLRX_REG_IRQ_MASK = 8'h4C;
    localparam int PLRX_LOS_THR_LSB = 5;
    localparam int PLRX_LOS_THR_MSB = 7;
    localparam logic [7:0] PLRX_LOS_THR_RESET = 8'h00;
    localparam int PLRX_CTRL_WIDE_BIT = 0;
    localparam logic [7:0] PLRX_CTRL_RESET = 8'h00;
    localparam int PLRX_IDLE_CNT_W = 8;
    // status word: detect done [3:0], detect result [7:4], idle state [11:8], idle sensed [15:12]
    localparam int PLRX_ST_DONE_LSB = 0;
    localparam int PLRX_ST_RES_LSB = 4;
    localparam int PLRX_ST_IDLE_LSB = 8;
    localparam int PLRX_ST_SENSE_LSB = 12;
    // interrupt events: detect done rise [3:0], idle sensed rise [7:4]
    localparam int PLRX_IRQ_DONE_LSB = 0;
    localparam int PLRX_IRQ_SENSE_LSB = 4;
    localparam int PLRX_IRQ_W = 8;
endpackage

// [rtl/plrx_lane_ctrl.sv]
// per-channel idle control, receiver detection and receive port of a four-channel lane quad
// What the document requires
// R1 - transmit buffers reach electrical idle within 120 ns of idle request rising
// R2 - transmit buffers leave idle after a bounded, parameterised delay once request falls
// R3 - no idle ordered set generated here; fabric sends it through transmit data
// R4 - receiver detection per channel, fully independent between the four channels
// R5 - fabric holds idle high at least 5 ms before raising detect request
// R6 - detect request high clears detect-done at once, without a clock edge
// R7 - fabric holds detect request about 1 us, plus or minus 0.5 us
// R8 - after request falls, done rises and detect result shows far-end presence
// R9 - fabric releases idle only after detect-done has risen
// R10 - receive data 8 bits, or 16 bits in wide mode, clocked by channel
// R11 - per-byte control-character flags, bit 1 upper byte, bit 0 lower byte
// R12 - per-byte disparity-error flag alongside the affected received byte
// R13 - per-byte invalid-code flag alongside the affected received byte
// R14 - descrambler starts the cycle after enable rises, stops the cycle after it falls
// R15 - polarity-invert input inverts incoming serial data while high
// R16 - idle-sensed output follows loss-of-signal low flag; threshold in config bits 7:5
// R17 - receive order: deserialise, align, decode, lane align, compensate, descramble
// R18 - detect result holds previous value until new result is presented
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module plrx_lane_ctrl
    import plrx_pkg::*;
#(
    parameter int NCH = PLRX_CHANNELS,
    parameter int IDLE_EXIT_CYC = PLRX_IDLE_EXIT_CYC
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    // fabric side per channel
    input wire logic [NCH-1:0] tx_idle_req_in,
    input wire logic [NCH-1:0] detect_test_in,
    output logic [NCH-1:0] detect_result_out,
    output logic [NCH-1:0] detect_done_out,
    input wire logic [NCH-1:0] descram_en_in,
    input wire logic [NCH-1:0] rx_polarity_inv_in,
    output logic [NCH-1:0] receive_idle_sensed_out,
    output logic [NCH*16-1:0] rx_data_out,
    output logic [NCH*2-1:0] rx_ctrl_char_out,
    output logic [NCH*2-1:0] rx_disp_err_out,
    output logic [NCH*2-1:0] receive_invalid_code_flag_out,
    // analogue front end side, per channel except the shared loss-of-signal threshold
    output logic [NCH-1:0] tx_buf_idle_out,
    output logic [NCH-1:0] rx_serial_invert_out,
    output logic [NCH-1:0] descram_active_out,
    output logic [NCH-1:0] detect_pulse_out,
    input wire logic [NCH-1:0] far_end_sensed_in,
    input wire logic [NCH-1:0] los_low_in,
    output logic [2:0] los_threshold_out,
    // decoded stream from the compensator, already in pipeline order
    input wire logic [NCH*16-1:0] dec_data_in,
    input wire logic [NCH*2-1:0] dec_ctrl_in,
    input wire logic [NCH*2-1:0] dec_disp_err_in,
    input wire logic [NCH*2-1:0] dec_code_err_in
);

    typedef enum logic [3:0] {
        PLRX_IDLE_OFF = 4'h1,
        PLRX_IDLE_ENTER = 4'h2,
        PLRX_IDLE_ON = 4'h4,
        PLRX_IDLE_EXIT = 4'h8
    } plrx_idle_state_t;

    logic [7:0] los_thr_r;
    logic [7:0] ctrl_r;
    logic [PLRX_IRQ_W-1:0] irq_stat_r;
    logic [PLRX_IRQ_W-1:0] irq_mask_r;
    logic [PLRX_IRQ_W-1:0] irq_evt;
    logic [NCH-1:0] done_r;
    logic [NCH-1:0] sense_r;
    logic wide_mode;
    logic [31:0] status_word;

    // width change applies from the next receive word on
    assign wide_mode = ctrl_r[PLRX_CTRL_WIDE_BIT];
    assign los_threshold_out = los_thr_r[PLRX_LOS_THR_MSB:PLRX_LOS_THR_LSB]; // [R16]

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            los_thr_r <= PLRX_LOS_THR_RESET;
            ctrl_r <= PLRX_CTRL_RESET;
            irq_mask_r <= '0;
        end
        else if (reg_wr_in)
        begin
            // writes to unmapped offsets change nothing
            if (reg_addr_in == PLRX_REG_LOS_THR)
            begin
                los_thr_r <= reg_wdata_in[7:0];
            end
            if (reg_addr_in == PLRX_REG_CTRL)
            begin
                ctrl_r <= reg_wdata_in[7:0];
            end
            if (reg_addr_in == PLRX_REG_IRQ_MASK)
            begin
                irq_mask_r <= reg_wdata_in[PLRX_IRQ_W-1:0];
            end
        end
    end

    // set beats a same-cycle write-one clear
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            irq_stat_r <= '0;
        end
        else if (reg_wr_in && reg_addr_in == PLRX_REG_IRQ_STAT)
        begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata_in[PLRX_IRQ_W-1:0]) | irq_evt;
        end
        else
        begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    assign irq_out = |(irq_stat_r & irq_mask_r);

    // fields placed by the shared bit positions; unused bits read as zero
    always_comb
    begin
        status_word = 32'h00000000;
        status_word[PLRX_ST_DONE_LSB +: NCH] = detect_done_out;
        status_word[PLRX_ST_RES_LSB +: NCH] = detect_result_out;
        status_word[PLRX_ST_IDLE_LSB +: NCH] = tx_buf_idle_out;
        status_word[PLRX_ST_SENSE_LSB +: NCH] = receive_idle_sensed_out;
    end

    // read data stand for one cycle only and read as zero otherwise
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            reg_rdata_out <= '0;
        end
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                PLRX_REG_LOS_THR: reg_rdata_out <= {24'h000000, los_thr_r};
                PLRX_REG_CTRL: reg_rdata_out <= {24'h000000, ctrl_r};
                PLRX_REG_STATUS: reg_rdata_out <= status_word;
                PLRX_REG_IRQ_STAT: reg_rdata_out <= {24'h000000, irq_stat_r};
                PLRX_REG_IRQ_MASK: reg_rdata_out <= {24'h000000, irq_mask_r};
                default: reg_rdata_out <= 32'h00000000;
            endcase
        end
        else
        begin
            reg_rdata_out <= 32'h00000000;
        end
    end

    // idle ordered sets are never built here; the fabric sends them as data [R3]
    generate
        for (genvar ch = 0; ch < NCH; ch++)
        begin : g_ch
            plrx_idle_state_t st_r;
            plrx_idle_state_t st_nxt;
            logic [PLRX_IDLE_CNT_W-1:0] cnt_r;
            logic [PLRX_IDLE_CNT_W-1:0] cnt_nxt;
            logic test_seen_r;
            logic done_q_r;
            logic result_r;
            logic descram_r;
            logic hi;
            logic done_prev_r;
            logic done_rise;
            logic sense_rise;

            // upper byte lane carries data only in wide mode
            assign hi = wide_mode;

            always_comb
            begin
                st_nxt = st_r;
                cnt_nxt = cnt_r;
                case (st_r)
                    PLRX_IDLE_OFF:
                    begin
                        if (tx_idle_req_in[ch])
                        begin
                            st_nxt = PLRX_IDLE_ENTER;
                            cnt_nxt = '0;
                        end
                    end
                    PLRX_IDLE_ENTER:
                    begin
                        // one cycle to the buffer, well inside the 120 ns budget [R1]
                        st_nxt = PLRX_IDLE_ON;
                    end
                    PLRX_IDLE_ON:
                    begin
                        if (!tx_idle_req_in[ch])
                        begin
                            st_nxt = PLRX_IDLE_EXIT;
                            cnt_nxt = '0;
                        end
                    end
                    PLRX_IDLE_EXIT:
                    begin
                        // exit delay must not exceed 2**PLRX_IDLE_CNT_W cycles
                        cnt_nxt = cnt_r + 1'b1;
                        if (tx_idle_req_in[ch])
                        begin
                            st_nxt = PLRX_IDLE_ON;
                        end
                        else if (cnt_r >= PLRX_IDLE_CNT_W'(IDLE_EXIT_CYC - 1)) // [R2]
                        begin
                            st_nxt = PLRX_IDLE_OFF;
                        end
                    end
                    default:
                    begin
                        st_nxt = PLRX_IDLE_OFF;
                    end
                endcase
            end

            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                begin
                    st_r <= PLRX_IDLE_OFF;
                    cnt_r <= '0;
                end
                else
                begin
                    st_r <= st_nxt;
                    cnt_r <= cnt_nxt;
                end
            end

            assign tx_buf_idle_out[ch] = (st_r == PLRX_IDLE_ENTER) || (st_r == PLRX_IDLE_ON)
                || (st_r == PLRX_IDLE_EXIT); // [R1] [R2]

            // each channel keeps its own test state, nothing shared [R4]
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                begin
                    test_seen_r <= 1'b0;
                    done_q_r <= 1'b0;
                    result_r <= 1'b0;
                end
                // a new request restarts the test, even in mid-test
                else if (detect_test_in[ch])
                begin
                    test_seen_r <= 1'b1;
                    done_q_r <= 1'b0;
                end
                else if (test_seen_r)
                begin
                    // result sampled as the request falls; held until then [R8] [R18]
                    test_seen_r <= 1'b0;
                    done_q_r <= 1'b1;
                    result_r <= far_end_sensed_in[ch];
                end
            end

            // request gates done directly, so clearing needs no edge [R6]
            assign done_r[ch] = done_q_r & ~detect_test_in[ch];
            assign detect_done_out[ch] = done_r[ch]; // [R8]
            assign detect_result_out[ch] = result_r; // [R18]
            // pulse timing is the fabric's; a test outside idle drives no pulse but still sets done and result [R7] [R5] [R9]
            assign detect_pulse_out[ch] = detect_test_in[ch] & tx_buf_idle_out[ch];

            // one flop each: descrambler acts from the cycle after its enable moves
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                begin
                    descram_r <= 1'b0;
                    sense_r[ch] <= 1'b0;
                end
                else
                begin
                    descram_r <= descram_en_in[ch]; // [R14]
                    sense_r[ch] <= los_low_in[ch]; // [R16]
                end
            end
            assign descram_active_out[ch] = descram_r;
            assign rx_serial_invert_out[ch] = rx_polarity_inv_in[ch]; // [R15]
            assign receive_idle_sensed_out[ch] = sense_r[ch];
            // each event lasts one cycle, as its level first rises
            assign done_rise = done_q_r & ~test_seen_r & ~detect_test_in[ch] & ~done_prev_r;
            assign sense_rise = los_low_in[ch] & ~sense_r[ch];
            assign irq_evt[PLRX_IRQ_DONE_LSB+ch] = done_rise;
            assign irq_evt[PLRX_IRQ_SENSE_LSB+ch] = sense_rise;

            // done one cycle back; both reset low, so no false edge after reset
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                begin
                    done_prev_r <= 1'b0;
                end
                else
                begin
                    done_prev_r <= done_q_r;
                end
            end

            // registered receive port; upper lane forced to zero in narrow mode [R10] [R17]
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                begin
                    rx_data_out[ch*16 +: 16] <= 16'h0000;
                    rx_ctrl_char_out[ch*2 +: 2] <= 2'h0;
                    rx_disp_err_out[ch*2 +: 2] <= 2'h0;
                    receive_invalid_code_flag_out[ch*2 +: 2] <= 2'h0;
                end
                else
                begin
                    rx_data_out[ch*16 +: 16] <= {dec_data_in[ch*16+8 +: 8] & {8{hi}},
                        dec_data_in[ch*16 +: 8]}; // [R10]
                    rx_ctrl_char_out[ch*2 +: 2] <= {dec_ctrl_in[ch*2+1] & hi,
                        dec_ctrl_in[ch*2]}; // [R11]
                    rx_disp_err_out[ch*2 +: 2] <= {dec_disp_err_in[ch*2+1] & hi,
                        dec_disp_err_in[ch*2]}; // [R12]
                    receive_invalid_code_flag_out[ch*2 +: 2] <= {dec_code_err_in[ch*2+1] & hi,
                        dec_code_err_in[ch*2]}; // [R13]
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// [test/plrx_lane_ctrl_sva.sv]
// concurrent checks on the lane control block ports
`timescale 1ns/1ps
`default_nettype none
module plrx_lane_ctrl_sva
    import plrx_pkg::*;
#(
    parameter int NCH = 4,
    parameter int IDLE_EXIT_CYC = 20
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic [NCH-1:0] tx_idle_req_in,
    input wire logic [NCH-1:0] detect_test_in,
    input wire logic [NCH-1:0] detect_result_out,
    input wire logic [NCH-1:0] detect_done_out,
    input wire logic [NCH-1:0] descram_en_in,
    input wire logic [NCH-1:0] descram_active_out,
    input wire logic [NCH-1:0] rx_polarity_inv_in,
    input wire logic [NCH-1:0] rx_serial_invert_out,
    input wire logic [NCH-1:0] tx_buf_idle_out,
    input wire logic [NCH-1:0] detect_pulse_out,
    input wire logic [NCH-1:0] far_end_sensed_in,
    input wire logic [2:0] los_threshold_out,
    input wire logic [NCH*16-1:0] rx_data_out,
    input wire logic [NCH*16-1:0] dec_data_in
);
    localparam int ENTER_MAX = PLRX_IDLE_ENTER_CYC;
    localparam int EXIT_MAX = IDLE_EXIT_CYC + 2;
    localparam logic [NCH*16-1:0] LO_BYTES = {NCH{16'h00FF}};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_DONE_CLR: assert property ((detect_test_in & detect_done_out) == '0)
        else $error("detect done high during test request");
    AST_DONE_SET: assert property ($past(rst_n_in) |->
        ($past(detect_test_in, 2) & ~$past(detect_test_in) & ~detect_test_in
        & ~detect_done_out) == '0) else $error("detect done missing after test end");
    AST_RESULT: assert property ($past(rst_n_in) |->
        ($past(detect_test_in, 2) & ~$past(detect_test_in)
        & (detect_result_out ^ $past(far_end_sensed_in))) == '0)
        else $error("detect result differs from far end");
    AST_RES_HOLD: assert property ($past(rst_n_in) |->
        ($past(detect_test_in) & (detect_result_out ^ $past(detect_result_out))) == '0)
        else $error("detect result moved during test");
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        AST_IDLE_ENTER: assert property ($rose(tx_idle_req_in[i]) |->
            ##[0:ENTER_MAX] tx_buf_idle_out[i]) else $error("idle entry too slow");
        AST_IDLE_EXIT: assert property ($fell(tx_idle_req_in[i]) |->
            ##[0:EXIT_MAX] (!tx_buf_idle_out[i] || tx_idle_req_in[i]))
            else $error("idle exit too slow");
    end
    AST_DESCRAM: assert property ($past(rst_n_in) |->
        descram_active_out == $past(descram_en_in)) else $error("descrambler lag wrong");
    AST_POLARITY: assert property (rx_serial_invert_out == rx_polarity_inv_in)
        else $error("polarity invert not followed");
    AST_PULSE: assert property (detect_pulse_out == (detect_test_in & tx_buf_idle_out))
        else $error("detect pulse not per channel");
    AST_LOS_THR: assert property ((reg_wr_in && reg_addr_in == PLRX_REG_LOS_THR) |=>
        los_threshold_out == $past(reg_wdata_in[7:5])) else $error("threshold not applied");
    AST_RX_LOW: assert property ($past(rst_n_in) |->
        (rx_data_out & LO_BYTES) == ($past(dec_data_in) & LO_BYTES))
        else $error("receive low bytes wrong");
endmodule
`default_nettype wire

// [test/plrx_fabric_model.sv]
// fabric-side model that runs the idle and receiver detection sequence
`timescale 1ns/1ps
`default_nettype none
module plrx_fabric_model
#(
    parameter int WAIT_CYC = 50,
    parameter int PULSE_CYC = 200
)
(
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [3:0] chan_in,
    input wire logic [3:0] done_in,
    output logic [3:0] idle_req_out,
    output logic [3:0] test_out,
    output logic busy_out
);
    initial
    begin
        idle_req_out = '0;
        test_out = '0;
        busy_out = 1'b0;
        forever
        begin
            @(posedge clk_in);
            if (go_in)
            begin
                busy_out <= 1'b1;
                idle_req_out <= chan_in;
                // settle wait shortened from milliseconds to keep the run short
                repeat (WAIT_CYC) @(posedge clk_in);
                test_out <= chan_in;
                repeat (PULSE_CYC) @(posedge clk_in);
                test_out <= '0;
                repeat (20) if ((done_in & chan_in) != chan_in) @(posedge clk_in);
                idle_req_out <= '0;
                busy_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the lane control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import plrx_pkg::*;
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, go = 1'b0;
    logic busy, irq_out;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic [3:0] chan = 4'h0, far_end_sensed_in = 4'h0, los_low_in = 4'h0;
    logic [3:0] descram_en_in = 4'h0, rx_polarity_inv_in = 4'h0;
    logic [3:0] tx_idle_req_in, detect_test_in, detect_result_out, detect_done_out;
    logic [3:0] receive_idle_sensed_out;
    logic [63:0] dec_data_in = 64'h0, rx_data_out;
    logic [7:0] dec_ctrl_in = 8'h00, dec_disp_err_in = 8'h00, dec_code_err_in = 8'h00;
    logic [7:0] rx_ctrl_char_out, rx_disp_err_out, receive_invalid_code_flag_out;
    int fail_count = 0, compares = 0, cycles = 0;
    plrx_lane_ctrl #(.NCH(4), .IDLE_EXIT_CYC(6)) dut (.clk_in, .rst_n_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .tx_idle_req_in,
        .detect_test_in, .detect_result_out, .detect_done_out, .descram_en_in,
        .rx_polarity_inv_in, .receive_idle_sensed_out, .rx_data_out, .rx_ctrl_char_out,
        .rx_disp_err_out, .receive_invalid_code_flag_out, .tx_buf_idle_out(),
        .rx_serial_invert_out(), .descram_active_out(), .detect_pulse_out(),
        .far_end_sensed_in, .los_low_in, .los_threshold_out(), .dec_data_in, .dec_ctrl_in,
        .dec_disp_err_in, .dec_code_err_in);
    plrx_fabric_model #(.WAIT_CYC(50), .PULSE_CYC(200)) fab (.clk_in, .go_in(go),
        .chan_in(chan), .done_in(detect_done_out), .idle_req_out(tx_idle_req_in),
        .test_out(detect_test_in), .busy_out(busy));
    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, e);
    endtask
    task automatic run(input logic [3:0] ch, input logic [3:0] fe);
        @(posedge clk_in);
        chan <= ch;
        far_end_sensed_in <= fe;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        while (busy) @(posedge clk_in);
        #1;
    endtask
    task automatic t_detect();
        run(4'hF, 4'hA);
        chk(detect_result_out, 4'hA);
        chk(detect_done_out, 4'hF);
        // one channel alone: the others must keep their old results
        run(4'h1, 4'h5);
        chk(detect_result_out, 4'hB);
        repeat (8) @(posedge clk_in);
        rd(PLRX_REG_STATUS, 32'h000000BF);
        rd(PLRX_REG_IRQ_STAT, 32'h0000000F);
        chk(irq_out, 1'b0);
        wr(PLRX_REG_IRQ_MASK, 32'h00000001);
        chk(irq_out, 1'b1);
        wr(PLRX_REG_IRQ_STAT, 32'h00000001);
        chk(irq_out, 1'b0);
        rd(PLRX_REG_IRQ_STAT, 32'h0000000E);
        $display("t_detect end");
    endtask
    task automatic t_rx();
        rd(PLRX_REG_LOS_THR, 32'h0);
        rd(PLRX_REG_CTRL, 32'h0);
        wr(PLRX_REG_LOS_THR, 32'h000000E0);
        rd(PLRX_REG_LOS_THR, 32'h000000E0);
        rd(8'h10, 32'h0);
        @(posedge clk_in);
        dec_data_in <= 64'h0123456789ABCDEF;
        dec_ctrl_in <= 8'hFF;
        dec_disp_err_in <= 8'h5A;
        dec_code_err_in <= 8'hC3;
        descram_en_in <= 4'h5;
        rx_polarity_inv_in <= 4'h9;
        los_low_in <= 4'h6;
        @(posedge clk_in);
        #1 chk(rx_data_out, 64'h0023006700AB00EF);
        chk(rx_ctrl_char_out, 8'h55);
        chk(rx_disp_err_out, 8'h50);
        chk(receive_invalid_code_flag_out, 8'h41);
        chk(receive_idle_sensed_out, 4'h6);
        wr(PLRX_REG_CTRL, 32'h00000001);
        @(posedge clk_in);
        #1 chk(rx_data_out, 64'h0123456789ABCDEF);
        chk(rx_ctrl_char_out, 8'hFF);
        chk(rx_disp_err_out, 8'h5A);
        chk(receive_invalid_code_flag_out, 8'hC3);
        rd(PLRX_REG_STATUS, 32'h000060BF);
        rd(PLRX_REG_IRQ_STAT, 32'h0000006E);
        wr(PLRX_REG_IRQ_MASK, 32'h00000020);
        chk(irq_out, 1'b1);
        @(posedge clk_in);
        descram_en_in <= 4'h0;
        repeat (2) @(posedge clk_in);
        $display("t_rx end");
    endtask
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_detect();
        t_rx();
        conclude();
    end
endmodule
bind plrx_lane_ctrl plrx_lane_ctrl_sva #(.NCH(NCH), .IDLE_EXIT_CYC(IDLE_EXIT_CYC)) u_sva (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .tx_idle_req_in(tx_idle_req_in),
    .detect_test_in(detect_test_in),
    .detect_result_out(detect_result_out),
    .detect_done_out(detect_done_out),
    .descram_en_in(descram_en_in),
    .descram_active_out(descram_active_out),
    .rx_polarity_inv_in(rx_polarity_inv_in),
    .rx_serial_invert_out(rx_serial_invert_out),
    .tx_buf_idle_out(tx_buf_idle_out),
    .detect_pulse_out(detect_pulse_out),
    .far_end_sensed_in(far_end_sensed_in),
    .los_threshold_out(los_threshold_out),
    .rx_data_out(rx_data_out),
    .dec_data_in(dec_data_in)
);
`default_nettype wire
